// ### bench/ptc_monitor.sv
// port checks for the paired timer and capture block
module ptc_monitor (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic capture_input_pin_i,
    input wire logic cpu_idle_i,
    input wire logic cpu_sleep_i,
    input wire logic capture_irq_o,
    input wire logic wake_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence rd_taken; s_axi_arvalid_i && s_axi_arready_o; endsequence
    sequence rd_answer; s_axi_rvalid_o && !s_axi_arready_o; endsequence
    rd_answer_a: assert property (rd_taken |=> rd_answer) else $error("late read");
    rd_release_a: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
        else $error("read stuck");
    wr_release_a: assert property (s_axi_bvalid_o && s_axi_bready_i
        |=> !s_axi_bvalid_o && s_axi_awready_o) else $error("write stuck");
    wr_hold_a: assert property ($rose(s_axi_bvalid_o) |-> !$past(s_axi_awready_o))
        else $error("early write answer");
    wake_mode_a: assert property (wake_o |-> cpu_sleep_i || cpu_idle_i) else $error("wake");
    wake_pulse_a: assert property (wake_o |=> !wake_o) else $error("long wake");
    wake_cause_a: assert property (wake_o |-> $past(capture_input_pin_i, 2))
        else $error("wake no pin");
    irq_hold_a: assert property ($fell(capture_irq_o)
        |-> $past(s_axi_wvalid_i) || $past(s_axi_wvalid_i, 2)) else $error("irq lost");
endmodule
bind ptc_top ptc_monitor u_mon (.*);

// ### bench/ptc_pin_src.sv
// capture pin source giving a burst of slow rising edges
module ptc_pin_src (
    input  wire logic       clk_i,
    input  wire logic       start_i,
    input  wire logic [4:0] count_i,
    output logic            pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] left = '0;
    logic [1:0] ph = '0;
    initial pin_o = 1'h0;
    always @(posedge clk_i) begin
        ph <= ph + 2'h1;
        if (start_i) left <= {count_i, 1'h0};
        else if (left != '0 && ph == 2'h3) begin
            pin_o <= ~pin_o;
            left <= left - 6'h1;
        end
    end
endmodule

// ### bench/tb.sv
// self-checking bench for the paired timer and capture block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [5:0] a; logic [31:0] d, e; logic [1:0] r;} ptc_row_t;
    logic core_clk_i = '0, resetn_i = '0, s_axi_awvalid_i = '0, s_axi_wvalid_i = '0;
    logic s_axi_bready_i = '0, s_axi_arvalid_i = '0, s_axi_rready_i = '0, cpu_sleep_i = '0;
    logic lower_ext_clock_pin_i = '0, upper_ext_clock_pin_i = '0, lower_gate_pin_i = '0;
    logic upper_gate_pin_i = '0, cpu_idle_i = '0, src_go = '0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic capture_input_pin_i, capture_irq_o, lower_match_o, upper_match_o, wake_o;
    logic [5:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
    logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o, rv;
    logic [3:0] s_axi_wstrb_i = 4'hF;
    logic [4:0] src_n = '0;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rs;
    int fail_count = 0, samples_checked = 0, cyc = 0, wakes = 0, ups = 0, los = 0;
    ptc_row_t rows [8] = '{'{6'h00, 32'hFFFF, 32'hA07A, 2'h0}, '{6'h04, 32'hFFFF, 32'hA072, 2'h0},
        '{6'h08, 32'hFFFF, 32'h20E7, 2'h0}, '{6'h14, 32'h1234, 32'h1234, 2'h0},
        '{6'h24, 32'h1, 32'h0, 2'h2}, '{6'h00, 32'h0, 32'h0, 2'h0},
        '{6'h04, 32'h0, 32'h0, 2'h0}, '{6'h08, 32'h0, 32'h0, 2'h0}};
    ptc_top DUT (.*);
    ptc_pin_src u_src (.clk_i(core_clk_i), .start_i(src_go), .count_i(src_n),
        .pin_o(capture_input_pin_i));
    always #50 core_clk_i = ~core_clk_i;
    task automatic test_done();
        if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        cyc++;
        wakes += wake_o;
        ups += upper_match_o;
        los += lower_match_o;
        if (cyc == 5000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'h1;
        s_axi_wvalid_i <= 1'h1;
        s_axi_bready_i <= 1'h1;
        do begin
            @(posedge core_clk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
        end while (!s_axi_bvalid_o);
        s_axi_bready_i <= 1'h0;
        rs = s_axi_bresp_o;
        @(posedge core_clk_i);
    endtask
    task automatic rd(input logic [5:0] a);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'h1;
        s_axi_rready_i <= 1'h1;
        do begin
            @(posedge core_clk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
        end while (!s_axi_rvalid_o);
        s_axi_rready_i <= 1'h0;
        rv = s_axi_rdata_o;
        rs = s_axi_rresp_o;
        @(posedge core_clk_i);
    endtask
    task automatic pulses(input logic [4:0] n);
        src_n <= n;
        src_go <= 1'h1;
        @(posedge core_clk_i);
        src_go <= 1'h0;
        repeat (8 * n + 8) @(posedge core_clk_i);
    endtask
    // one rising edge on the lower external clock pin
    task automatic tick();
        lower_ext_clock_pin_i <= 1'h1;
        repeat (4) @(posedge core_clk_i);
        lower_ext_clock_pin_i <= 1'h0;
        repeat (4) @(posedge core_clk_i);
    endtask
    initial begin
        repeat (6) @(posedge core_clk_i);
        resetn_i <= 1'h1;
        repeat (3) @(posedge core_clk_i);
        rd(6'h18);
        chk(rv, 32'hFFFF);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk(32'(rs), 32'(rows[i].r));
            rd(rows[i].a);
            chk(rv, rows[i].e);
        end
        wr(6'h08, 32'h83);
        for (int k = 1; k <= 5; k++) begin
            wr(6'h0C, 32'(k));
            pulses(5'h1);
        end
        rd(6'h08);
        chk(rv, 32'h9B);
        for (int k = 1; k <= 4; k++) begin
            rd(6'h1C);
            chk(rv, 32'(k));
        end
        rd(6'h08);
        chk(rv, 32'h93);
        chk(32'(capture_irq_o), 32'h1);
        wr(6'h08, 32'h0);
        rd(6'h08);
        chk(rv, 32'h0);
        wr(6'h20, 32'h1);
        chk(32'(capture_irq_o), 32'h0);
        wr(6'h10, 32'h55);
        wr(6'h08, 32'h24);
        pulses(5'h7);
        chk(32'(capture_irq_o), 32'h0);
        rd(6'h08);
        chk(rv, 32'h2C);
        pulses(5'h1);
        chk(32'(capture_irq_o), 32'h1);
        rd(6'h1C);
        chk(rv, 32'h55);
        rd(6'h1C);
        chk(rv, 32'h55);
        wr(6'h08, 32'h07);
        cpu_sleep_i <= 1'h1;
        pulses(5'h1);
        chk(32'(wakes), 32'h1);
        rd(6'h08);
        chk(rv, 32'h07);
        cpu_sleep_i <= 1'h0;
        pulses(5'h1);
        chk(32'(wakes), 32'h1);
        wr(6'h08, 32'h61);
        wr(6'h20, 32'h1);
        pulses(5'h1);
        chk(32'(capture_irq_o), 32'h1);
        rd(6'h08);
        chk(rv, 32'h69);
        wr(6'h20, 32'h7);
        wr(6'h00, 32'h800A);
        wr(6'h04, 32'h8000);
        wr(6'h14, 32'hFFFF);
        wr(6'h0C, 32'hFFFF);
        wr(6'h10, 32'h2);
        tick();
        rd(6'h0C);
        chk(rv, 32'h0);
        rd(6'h10);
        chk(rv, 32'h3);
        wr(6'h14, 32'h0);
        wr(6'h18, 32'h3);
        tick();
        chk(32'(ups), 32'h1);
        chk(32'(los), 32'h0);
        rd(6'h20);
        chk(rv, 32'h4);
        rd(6'h10);
        chk(rv, 32'h0);
        wr(6'h00, 32'hA002);
        tick();
        chk(32'(los), 32'h1);
        cpu_idle_i <= 1'h1;
        tick();
        chk(32'(los), 32'h1);
        test_done();
    end
endmodule

// ### rtl/ptc_prescaler.sv
// one timer's clock select, gate and prescale stage
module ptc_prescaler (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       run_i,
    input  wire logic       ext_sel_i,
    input  wire logic       gate_en_i,
    input  wire logic       gate_i,
    input  wire logic       ext_rise_i,
    input  wire logic [1:0] ps_sel_i,
    output logic            tick_o
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [7:0] last;
    logic       src;

    always_comb begin
        unique case (ps_sel_i)
            2'h0: last = ptc_pkg::PS_DIV1;
            2'h1: last = ptc_pkg::PS_DIV8;
            2'h2: last = ptc_pkg::PS_DIV64;
            2'h3: last = ptc_pkg::PS_DIV256;
        endcase
        // gate only counts with the internal clock
        src = ext_sel_i ? ext_rise_i : (!gate_en_i || gate_i);
        next_cnt = cnt;
        tick_o = 1'b0;
        if (!run_i) begin
            next_cnt = 8'h00;
        end else if (src) begin
            if (cnt >= last) begin
                next_cnt = 8'h00;
                tick_o = 1'b1;
            end else begin
                next_cnt = cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 8'h00;
        end else begin
            cnt <= next_cnt;
        end
    end
endmodule

// ### rtl/ptc_top.sv
// paired 16/32-bit timers with an input capture channel and AXI4-Lite registers
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
module ptc_top (
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    input  wire logic [5:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [5:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire logic        lower_ext_clock_pin_i,
    input  wire logic        upper_ext_clock_pin_i,
    input  wire logic        lower_gate_pin_i,
    input  wire logic        upper_gate_pin_i,
    input  wire logic        capture_input_pin_i,
    input  wire logic        cpu_idle_i,
    input  wire logic        cpu_sleep_i,
    output logic             capture_irq_o,
    output logic             lower_match_o,
    output logic             upper_match_o,
    output logic             wake_o
);
    logic [1:0]  rst_sync;
    logic        rst_n;
    logic [15:0] lower_timer_control, upper_timer_control, capture_channel_control;
    logic [15:0] next_lower_ctrl, next_upper_ctrl, next_cap_ctrl;
    logic [15:0] lower_count, upper_count, next_lower_count, next_upper_count;
    logic [15:0] lower_period, upper_period, next_lower_period, next_upper_period;
    logic [15:0] fifo_mem [ptc_pkg::FIFO_DEPTH];
    logic [15:0] next_fifo_mem [ptc_pkg::FIFO_DEPTH];
    logic [1:0]  wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [2:0]  fill, next_fill;
    logic        ovf, next_ovf;
    logic [3:0]  edge_pre, next_edge_pre;
    logic [1:0]  irq_cnt, next_irq_cnt;
    logic [2:0]  sticky, next_sticky;
    logic [2:0]  pin_s1, pin_s2, pin_s3;
    logic        aw_held, w_held, next_aw_held, next_w_held;
    logic [5:0]  aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0]  w_strb, next_w_strb;
    logic        bvalid, next_bvalid, bslverr, next_bslverr;
    logic        rvalid, next_rvalid, rslverr, next_rslverr;
    logic [31:0] rdata, next_rdata;
    logic        join_mode, lower_run, upper_run, lower_tick, upper_tick;
    logic        lower_hit, upper_hit, cap_rise, cap_fall, cap_event, cap_on, buf_pop;
    logic        wr_fire, rd_fire, lower_ext_rise, upper_ext_rise;
    logic [2:0]  cap_mode;
    logic [15:0] lo_ctrl_eff;

    // reset release through two flops
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // pins: two-flop sync, third flop for edges; order capture, upper clk, lower clk
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 3'h0;
            pin_s2 <= 3'h0;
            pin_s3 <= 3'h0;
        end else begin
            pin_s1 <= {capture_input_pin_i, upper_ext_clock_pin_i, lower_ext_clock_pin_i};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end
    assign lower_ext_rise = pin_s2[0] && !pin_s3[0];
    assign upper_ext_rise = pin_s2[1] && !pin_s3[1];
    assign cap_rise       = pin_s2[2] && !pin_s3[2];
    assign cap_fall       = !pin_s2[2] && pin_s3[2];

    assign lo_ctrl_eff = lower_timer_control;
    assign join_mode = lo_ctrl_eff[ptc_pkg::B_JOIN];
    assign lower_run = lo_ctrl_eff[ptc_pkg::B_RUN]
                       && !(cpu_idle_i && lo_ctrl_eff[ptc_pkg::B_IDLE]);
    assign upper_run = upper_timer_control[ptc_pkg::B_RUN] && !join_mode
                       && !(cpu_idle_i && upper_timer_control[ptc_pkg::B_IDLE]);

    ptc_prescaler u_lower_ps (
        .clk_i      (core_clk_i),
        .rst_n_i    (rst_n),
        .run_i      (lower_run),
        .ext_sel_i  (lo_ctrl_eff[ptc_pkg::B_CS]),
        .gate_en_i  (lo_ctrl_eff[ptc_pkg::B_GATE]),
        .gate_i     (lower_gate_pin_i),
        .ext_rise_i (lower_ext_rise),
        .ps_sel_i   (lo_ctrl_eff[ptc_pkg::B_PS_LO +: 2]),
        .tick_o     (lower_tick)
    );

    ptc_prescaler u_upper_ps (
        .clk_i      (core_clk_i),
        .rst_n_i    (rst_n),
        .run_i      (upper_run),
        .ext_sel_i  (upper_timer_control[ptc_pkg::B_CS]),
        .gate_en_i  (upper_timer_control[ptc_pkg::B_GATE]),
        .gate_i     (upper_gate_pin_i),
        .ext_rise_i (upper_ext_rise),
        .ps_sel_i   (upper_timer_control[ptc_pkg::B_PS_LO +: 2]),
        .tick_o     (upper_tick)
    );

    // period matches
    always_comb begin
        if (join_mode) begin
            lower_hit = 1'b0;
            upper_hit = lower_tick && {upper_count, lower_count}
                        == {upper_period, lower_period};
        end else begin
            lower_hit = lower_tick && lower_count == lower_period;
            upper_hit = upper_tick && upper_count == upper_period;
        end
    end
    assign lower_match_o = lower_hit;
    assign upper_match_o = upper_hit;

    assign cap_mode = capture_channel_control[2:0];
    assign cap_on = !(cpu_idle_i && capture_channel_control[ptc_pkg::B_CIDLE]);
    assign wake_o = (cpu_sleep_i || cpu_idle_i) && cap_mode == ptc_pkg::CM_WAKE
                    && cap_rise;

    // capture event qualification
    always_comb begin
        cap_event = 1'b0;
        next_edge_pre = edge_pre;
        unique case (cap_mode)
            ptc_pkg::CM_BOTH:  cap_event = cap_rise || cap_fall;
            ptc_pkg::CM_FALL:  cap_event = cap_fall;
            ptc_pkg::CM_RISE:  cap_event = cap_rise;
            ptc_pkg::CM_RISE4, ptc_pkg::CM_RISE16: begin
                if (cap_rise && cap_on) begin
                    if (edge_pre == (cap_mode == ptc_pkg::CM_RISE4 ? ptc_pkg::PRE4_LAST
                                                                   : ptc_pkg::PRE16_LAST)) begin
                        next_edge_pre = 4'h0;
                        cap_event = 1'b1;
                    end else begin
                        next_edge_pre = edge_pre + 4'h1;
                    end
                end
            end
            ptc_pkg::CM_OFF, ptc_pkg::CM_UNUSED, ptc_pkg::CM_WAKE: begin
                next_edge_pre = 4'h0;
            end
        endcase
        cap_event = cap_event && cap_on;
    end

    assign wr_fire = aw_held && w_held && !bvalid;
    assign rd_fire = s_axi_arvalid_i && !rvalid;
    assign buf_pop = rd_fire && s_axi_araddr_i == ptc_pkg::OFF_CAP_BUF && fill != 3'h0;

    // timers, fifo, control and status registers
    always_comb begin
        next_lower_ctrl = lower_timer_control;
        next_upper_ctrl = upper_timer_control;
        next_cap_ctrl = capture_channel_control;
        next_lower_period = lower_period;
        next_upper_period = upper_period;
        next_lower_count = lower_count;
        next_upper_count = upper_count;
        next_fifo_mem = fifo_mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_fill = fill;
        next_ovf = ovf;
        next_irq_cnt = irq_cnt;
        next_sticky = sticky;
        if (join_mode) begin
            if (upper_hit) begin
                next_lower_count = 16'h0000;
                next_upper_count = 16'h0000;
            end else if (lower_tick) begin
                {next_upper_count, next_lower_count} = {upper_count, lower_count} + 32'h1;
            end
        end else begin
            if (lower_hit) begin
                next_lower_count = 16'h0000;
            end else if (lower_tick) begin
                next_lower_count = lower_count + 16'h0001;
            end
            if (upper_hit) begin
                next_upper_count = 16'h0000;
            end else if (upper_tick) begin
                next_upper_count = upper_count + 16'h0001;
            end
        end
        if (wr_fire) begin
            unique case (aw_addr)
                ptc_pkg::OFF_LOWER_CTRL:  next_lower_ctrl = w_data[15:0] & ptc_pkg::LOWER_CTRL_MASK;
                ptc_pkg::OFF_UPPER_CTRL:  next_upper_ctrl = w_data[15:0] & ptc_pkg::UPPER_CTRL_MASK;
                ptc_pkg::OFF_CAP_CTRL:    next_cap_ctrl = w_data[15:0] & ptc_pkg::CAP_CTRL_MASK;
                ptc_pkg::OFF_LOWER_COUNT: next_lower_count = w_data[15:0];
                ptc_pkg::OFF_UPPER_COUNT: next_upper_count = w_data[15:0];
                ptc_pkg::OFF_LOWER_PER:   next_lower_period = w_data[15:0];
                ptc_pkg::OFF_UPPER_PER:   next_upper_period = w_data[15:0];
                ptc_pkg::OFF_STATUS:      next_sticky = sticky & ~w_data[2:0];
                default: ;
            endcase
            // turning the channel off clears its buffer and overflow flag; a buffer read in the same cycle still pops, a capture still pushes or sets overflow
            if (aw_addr == ptc_pkg::OFF_CAP_CTRL && w_data[2:0] == ptc_pkg::CM_OFF) begin
                next_fill = 3'h0;
                next_rd_ptr = 2'h0;
                next_wr_ptr = 2'h0;
                next_ovf = 1'b0;
                next_irq_cnt = 2'h0;
            end
        end
        if (buf_pop) begin
            next_rd_ptr = rd_ptr + 2'h1;
            next_fill = next_fill - 3'h1;
        end
        if (cap_event) begin
            if (fill == ptc_pkg::FIFO_FULL && !buf_pop) begin
                next_ovf = 1'b1;
            end else begin
                next_fifo_mem[wr_ptr] = capture_channel_control[ptc_pkg::B_CTB]
                                        ? lower_count : upper_count;
                next_wr_ptr = wr_ptr + 2'h1;
                next_fill = next_fill + 3'h1;
            end
            if (cap_mode == ptc_pkg::CM_BOTH
                || irq_cnt == capture_channel_control[ptc_pkg::B_CPI +: 2]) begin
                next_irq_cnt = 2'h0;
                next_sticky[ptc_pkg::B_ST_CAPIRQ] = 1'b1;
            end else begin
                next_irq_cnt = irq_cnt + 2'h1;
            end
        end
        if (wake_o) begin
            next_sticky[ptc_pkg::B_ST_CAPIRQ] = 1'b1;
        end
        if (lower_hit) begin
            next_sticky[ptc_pkg::B_ST_LOIRQ] = 1'b1;
        end
        if (upper_hit) begin
            next_sticky[ptc_pkg::B_ST_UPIRQ] = 1'b1;
        end
    end
    assign capture_irq_o = sticky[ptc_pkg::B_ST_CAPIRQ];

    // AXI4-Lite handshake
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bslverr = bslverr;
        next_rvalid = rvalid;
        next_rslverr = rslverr;
        next_rdata = rdata;
        if (s_axi_awvalid_i && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata_i;
            next_w_strb = s_axi_wstrb_i;
        end
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bslverr = aw_addr > ptc_pkg::OFF_STATUS || aw_addr[1:0] != 2'h0;
        end
        if (bvalid && s_axi_bready_i) begin
            next_bvalid = 1'b0;
        end
        if (rd_fire) begin
            next_rvalid = 1'b1;
            next_rslverr = 1'b0;
            unique case (s_axi_araddr_i)
                ptc_pkg::OFF_LOWER_CTRL:  next_rdata = {16'h0000, lower_timer_control};
                ptc_pkg::OFF_UPPER_CTRL:  next_rdata = {16'h0000, upper_timer_control};
                ptc_pkg::OFF_CAP_CTRL: begin
                    next_rdata = {16'h0000, capture_channel_control};
                    next_rdata[ptc_pkg::B_OVF] = ovf;
                    next_rdata[ptc_pkg::B_BNE] = fill != 3'h0;
                end
                ptc_pkg::OFF_LOWER_COUNT: next_rdata = {16'h0000, lower_count};
                ptc_pkg::OFF_UPPER_COUNT: next_rdata = {16'h0000, upper_count};
                ptc_pkg::OFF_LOWER_PER:   next_rdata = {16'h0000, lower_period};
                ptc_pkg::OFF_UPPER_PER:   next_rdata = {16'h0000, upper_period};
                ptc_pkg::OFF_CAP_BUF:     next_rdata = {16'h0000, fifo_mem[rd_ptr]};
                ptc_pkg::OFF_STATUS:      next_rdata = {29'h0, sticky};
                default: begin
                    next_rdata = 32'h0;
                    next_rslverr = 1'b1;
                end
            endcase
        end
        if (rvalid && s_axi_rready_i) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            lower_timer_control <= 16'h0000;
            upper_timer_control <= 16'h0000;
            capture_channel_control <= 16'h0000;
            lower_count <= 16'h0000;
            upper_count <= 16'h0000;
            lower_period <= ptc_pkg::PER_RESET;
            upper_period <= ptc_pkg::PER_RESET;
            for (int i = 0; i < ptc_pkg::FIFO_DEPTH; i++) begin
                fifo_mem[i] <= 16'h0000;
            end
            wr_ptr <= 2'h0;
            rd_ptr <= 2'h0;
            fill <= 3'h0;
            ovf <= 1'b0;
            edge_pre <= 4'h0;
            irq_cnt <= 2'h0;
            sticky <= 3'h0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 6'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bslverr <= 1'b0;
            rvalid <= 1'b0;
            rslverr <= 1'b0;
            rdata <= 32'h0;
        end else begin
            lower_timer_control <= next_lower_ctrl;
            upper_timer_control <= next_upper_ctrl;
            capture_channel_control <= next_cap_ctrl;
            lower_count <= next_lower_count;
            upper_count <= next_upper_count;
            lower_period <= next_lower_period;
            upper_period <= next_upper_period;
            fifo_mem <= next_fifo_mem;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            fill <= next_fill;
            ovf <= next_ovf;
            edge_pre <= next_edge_pre;
            irq_cnt <= next_irq_cnt;
            sticky <= next_sticky;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bslverr <= next_bslverr;
            rvalid <= next_rvalid;
            rslverr <= next_rslverr;
            rdata <= next_rdata;
        end
    end

    assign s_axi_awready_o = !aw_held;
    assign s_axi_wready_o = !w_held;
    assign s_axi_bvalid_o = bvalid;
    assign s_axi_bresp_o = bslverr ? ptc_pkg::RESP_SLVERR : ptc_pkg::RESP_OKAY;
    assign s_axi_arready_o = !rvalid;
    assign s_axi_rvalid_o = rvalid;
    assign s_axi_rdata_o = rdata;
    assign s_axi_rresp_o = rslverr ? ptc_pkg::RESP_SLVERR : ptc_pkg::RESP_OKAY;
endmodule

// ### shared/ptc_pkg.sv
// constants for the paired timer and input capture block
package ptc_pkg;
    // register byte offsets
    localparam logic [5:0] OFF_LOWER_CTRL  = 6'h00;
    localparam logic [5:0] OFF_UPPER_CTRL  = 6'h04;
    localparam logic [5:0] OFF_CAP_CTRL    = 6'h08;
    localparam logic [5:0] OFF_LOWER_COUNT = 6'h0C;
    localparam logic [5:0] OFF_UPPER_COUNT = 6'h10;
    localparam logic [5:0] OFF_LOWER_PER   = 6'h14;
    localparam logic [5:0] OFF_UPPER_PER   = 6'h18;
    localparam logic [5:0] OFF_CAP_BUF     = 6'h1C;
    localparam logic [5:0] OFF_STATUS      = 6'h20;
    // timer control fields
    localparam int B_RUN   = 15;
    localparam int B_IDLE  = 13;
    localparam int B_GATE  = 6;
    localparam int B_PS_LO = 4;
    localparam int B_JOIN  = 3;
    localparam int B_CS    = 1;
    localparam logic [15:0] LOWER_CTRL_MASK = 16'hA07A;
    localparam logic [15:0] UPPER_CTRL_MASK = 16'hA072;
    // capture control fields
    localparam int B_CIDLE = 13;
    localparam int B_CTB   = 7;
    localparam int B_CPI   = 5;
    localparam int B_OVF   = 4;
    localparam int B_BNE   = 3;
    localparam logic [15:0] CAP_CTRL_MASK = 16'h20E7;
    // status register bits
    localparam int B_ST_CAPIRQ = 0;
    localparam int B_ST_LOIRQ  = 1;
    localparam int B_ST_UPIRQ  = 2;
    // capture modes
    localparam logic [2:0] CM_OFF   = 3'h0;
    localparam logic [2:0] CM_BOTH  = 3'h1;
    localparam logic [2:0] CM_FALL  = 3'h2;
    localparam logic [2:0] CM_RISE  = 3'h3;
    localparam logic [2:0] CM_RISE4 = 3'h4;
    localparam logic [2:0] CM_RISE16 = 3'h5;
    localparam logic [2:0] CM_UNUSED = 3'h6;
    localparam logic [2:0] CM_WAKE  = 3'h7;
    // prescale terminal counts
    localparam logic [7:0] PS_DIV1   = 8'h00;
    localparam logic [7:0] PS_DIV8   = 8'h07;
    localparam logic [7:0] PS_DIV64  = 8'h3F;
    localparam logic [7:0] PS_DIV256 = 8'hFF;
    localparam logic [3:0] PRE4_LAST  = 4'h3;
    localparam logic [3:0] PRE16_LAST = 4'hF;
    localparam int FIFO_DEPTH = 4;
    localparam logic [2:0] FIFO_FULL = 3'h4;
    localparam logic [15:0] PER_RESET = 16'hFFFF;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
